// ===== design/acsc_params.svh
`ifndef ACSC_PARAMS_SVH
`define ACSC_PARAMS_SVH
// ==========================================================
// Configuration word layout
`define ACSC_SS_BIT        15
`define ACSC_MUX_MSB       14
`define ACSC_MUX_LSB       12
`define ACSC_GAIN_MSB      11
`define ACSC_GAIN_LSB      9
`define ACSC_MODE_BIT      8
`define ACSC_RATE_MSB      7
`define ACSC_RATE_LSB      5
`define ACSC_TEMP_BIT      4
`define ACSC_PULL_BIT      3
`define ACSC_QUAL_MSB      2
`define ACSC_QUAL_LSB      1
`define ACSC_RSVD_BIT      0
`define ACSC_QUAL_VALID    2'h1
`define ACSC_CFG_RESET     16'h058b
// ==========================================================
// Timing
`define ACSC_CLK_PERIOD_NS 5
`define ACSC_TIMEOUT_MS    28
`define ACSC_TIMEOUT_CYC   ((`ACSC_TIMEOUT_MS * 1000000) / `ACSC_CLK_PERIOD_NS)
// ==========================================================
// Host register offsets (AXI4-Lite byte addresses)
`define ACSC_REG_CTRL      12'h000
`define ACSC_REG_CFG       12'h004
`define ACSC_REG_RESULT    12'h008
`define ACSC_REG_RDBK      12'h00c
`define ACSC_REG_STAT      12'h010
`define ACSC_REG_MASK      12'h014
`define ACSC_REG_DIV       12'h018
`define ACSC_DIV_RESET     16'h0005
`endif

// ===== design/acsc_pkg.sv
package acsc_pkg;
  // Sample rate codes
  typedef enum logic [2:0] {
    ACSC_SPS_128  = 3'h0,
    ACSC_SPS_250  = 3'h1,
    ACSC_SPS_490  = 3'h2,
    ACSC_SPS_920  = 3'h3,
    ACSC_SPS_1600 = 3'h4,
    ACSC_SPS_2400 = 3'h5,
    ACSC_SPS_3300 = 3'h6,
    ACSC_SPS_NONE = 3'h7
  } acsc_rate_t;
  // Link side state of the device end
  typedef enum logic [2:0] {
    ACSC_D_IDLE  = 3'b001,
    ACSC_D_SHIFT = 3'b010,
    ACSC_D_DONE  = 3'b100
  } acsc_dev_state_t;
  // Host end sequencing
  typedef enum logic [3:0] {
    ACSC_H_IDLE = 4'b0001,
    ACSC_H_HIGH = 4'b0010,
    ACSC_H_LOW  = 4'b0100,
    ACSC_H_END  = 4'b1000
  } acsc_host_state_t;
endpackage

// ===== design/acsc_link_if.sv
`timescale 1ns/1ps
// ==========================================================
// Serial link between host and converter
interface acsc_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic dout_pull;
  logic dout;
  // Resolved line: driven value, else weak pullup; a floating line reads low here
  assign dout = dout_oe ? dout_o : dout_pull;
  modport device (input sclk, input cs_n, input din,
                  output dout_o, output dout_oe, output dout_pull);
  modport host (output sclk, output cs_n, output din, input dout);
endinterface

// ===== design/acsc_device.sv
`timescale 1ns/1ps
`include "acsc_params.svh"
module acsc_device
  import acsc_pkg::*;
#(
  parameter int TIMEOUT_CYC = `ACSC_TIMEOUT_CYC
)(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // Serial link
  acsc_link_if.device      LINK,
  // Converter core side
  input  wire logic [11:0] RESULT_DATA,
  input  wire logic        RESULT_VALID,
  output logic             CONV_START,
  output logic             CONV_BUSY_CLR,
  input  wire logic        CONV_BUSY,
  output logic [2:0]       MUX_SEL,
  output logic [2:0]       GAIN_RANGE_SELECT,
  output logic             CONTINUOUS_MODE,
  output logic [2:0]       SAMPLE_RATE_SELECT,
  output logic             TEMPERATURE_SENSOR_SELECT
);
  initial
  begin
    if (TIMEOUT_CYC < 2)
      $error("TIMEOUT_CYC too small");
  end

  // ==========================================================
  // Pin synchronisers
  logic [1:0] sclk_s_q, cs_s_q, din_s_q;
  logic       sclk_d1_q;
  always_ff @(posedge CLK)
  begin
    sclk_s_q <= {sclk_s_q[0], LINK.sclk};
    cs_s_q   <= {cs_s_q[0], LINK.cs_n};
    din_s_q  <= {din_s_q[0], LINK.din};
    sclk_d1_q <= SRST ? 1'b0 : sclk_s_q[1];
  end

  wire sclk_w = sclk_s_q[1];
  wire cs_n_w = SRST ? 1'b1 : cs_s_q[1];
  wire din_w  = din_s_q[1];
  wire rise_w = sclk_w & ~sclk_d1_q;  // Launch edge
  wire fall_w = ~sclk_w & sclk_d1_q;  // Sample edge

  // ==========================================================
  // Registers
  acsc_dev_state_t state_q;
  logic [15:0] cfg_q;
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [15:0] result_q;
  logic        new_q;
  logic [4:0]  bit_cnt_q;
  logic        dout_q;
  logic [31:0] low_cnt_q;

  // Received word decoding
  wire [15:0] word_w      = {rx_q[14:0], din_w};
  wire [1:0]  qual_w      = word_w[`ACSC_QUAL_MSB:`ACSC_QUAL_LSB];
  wire        qual_ok_w   = (qual_w == `ACSC_QUAL_VALID);
  wire        word_done_w = fall_w && (bit_cnt_q[3:0] == 4'hf);
  wire        apply_w     = (state_q == ACSC_D_SHIFT) && word_done_w && qual_ok_w
                            && (bit_cnt_q == 5'h0f);
  wire        powered_dn_w = cfg_q[`ACSC_MODE_BIT] && !CONV_BUSY;
  wire        start_w     = apply_w && word_w[`ACSC_SS_BIT] && word_w[`ACSC_MODE_BIT]
                            && powered_dn_w;
  wire        timeout_w   = (state_q == ACSC_D_SHIFT) && !sclk_w
                            && (low_cnt_q >= 32'(TIMEOUT_CYC));
  // Readback word: start bit reads zero, reserved bit reads one
  wire [15:0] rdbk_w      = {1'b0, cfg_q[14:1], 1'b1};

  // ==========================================================
  // Transfer state machine
  always_ff @(posedge CLK)
  begin
    if (SRST || cs_n_w || timeout_w)
    begin
      state_q   <= ACSC_D_IDLE;
      bit_cnt_q <= 5'h00;
      low_cnt_q <= 32'h0;
    end
    else
    begin
      low_cnt_q <= sclk_w ? 32'h0 : low_cnt_q + 32'h1;
      unique case (state_q)
        ACSC_D_IDLE:
        begin
          state_q <= ACSC_D_SHIFT;
        end
        ACSC_D_SHIFT:
        begin
          if (fall_w)
            bit_cnt_q <= bit_cnt_q + 5'h01;
          if (fall_w && bit_cnt_q == 5'h1f)
            state_q <= ACSC_D_DONE;
        end
        ACSC_D_DONE:
        begin
          state_q <= ACSC_D_DONE;
        end
      endcase
    end
  end

  // Shift registers and output data; a timed out transfer restarts at bit zero while still selected
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      rx_q   <= 16'h0;
      tx_q   <= 16'h0;
      dout_q <= 1'b1;
    end
    else if (state_q == ACSC_D_IDLE)
    begin
      tx_q   <= result_q;
      dout_q <= ~new_q;
    end
    else
    begin
      if (fall_w)
        rx_q <= word_w;
      // Readback is loaded after the sixteenth sample, so a word applied
      // in this frame is already in the register when it is shifted out
      if (rise_w && bit_cnt_q == 5'h10)
      begin
        dout_q <= rdbk_w[15];
        tx_q   <= {rdbk_w[14:0], 1'b0};
      end
      else if (rise_w)
      begin
        dout_q <= tx_q[15];
        tx_q   <= {tx_q[14:0], 1'b0};
      end
    end
  end

  // Configuration and result buffer
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      cfg_q    <= `ACSC_CFG_RESET;
      result_q <= 16'h0;
      new_q    <= 1'b0;
    end
    else
    begin
      if (apply_w)
        cfg_q <= {1'b0, word_w[14:1], 1'b1};
      if (RESULT_VALID)
        result_q <= {RESULT_DATA, 4'h0};
      // New data wins over the clear taken at the start of a read
      if (RESULT_VALID)
        new_q <= 1'b1;
      else if (state_q == ACSC_D_IDLE && !cs_n_w)
        new_q <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge CLK)
  begin
    CONV_START <= SRST ? 1'b0 : start_w;
  end
  assign CONV_BUSY_CLR             = 1'b0;
  assign MUX_SEL                   = cfg_q[`ACSC_MUX_MSB:`ACSC_MUX_LSB];
  assign GAIN_RANGE_SELECT         = cfg_q[`ACSC_GAIN_MSB:`ACSC_GAIN_LSB];
  assign CONTINUOUS_MODE           = ~cfg_q[`ACSC_MODE_BIT];
  assign SAMPLE_RATE_SELECT        = cfg_q[`ACSC_RATE_MSB:`ACSC_RATE_LSB];
  assign TEMPERATURE_SENSOR_SELECT = cfg_q[`ACSC_TEMP_BIT];
  // Drive only while selected; pullup only when deselected and enabled
  assign LINK.dout_o    = dout_q;
  assign LINK.dout_oe   = ~cs_n_w;
  assign LINK.dout_pull = cs_n_w & cfg_q[`ACSC_PULL_BIT];
endmodule

// ===== design/acsc_host.sv
`timescale 1ns/1ps
`include "acsc_params.svh"
module acsc_host
  import acsc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // AXI4-Lite slave
  input  wire logic [11:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [11:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // Interrupt
  output logic             IRQ,
  // Serial link
  acsc_link_if.host        LINK
);
  // ==========================================================
  // Bus slave: address and data latched separately
  logic        aw_q, w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [15:0] cfg_q, div_q, result_q, rdbk_q;
  logic [1:0]  stat_q, mask_q;
  logic        go_q, long_q;
  acsc_host_state_t st_q;
  logic [15:0] div_cnt_q;
  logic [5:0]  edge_q;
  logic [31:0] sh_out_q, sh_in_q;
  logic        din_s1_q, din_s2_q;

  wire wr_w   = aw_q && w_q && !BVALID;
  wire busy_w = (st_q != ACSC_H_IDLE);
  wire hit_w  = (awaddr_q == `ACSC_REG_CTRL) || (awaddr_q == `ACSC_REG_CFG)
                || (awaddr_q == `ACSC_REG_STAT) || (awaddr_q == `ACSC_REG_MASK)
                || (awaddr_q == `ACSC_REG_DIV);
  wire done_w = (st_q == ACSC_H_END);
  assign AWREADY = !aw_q;
  assign WREADY  = !w_q;
  assign ARREADY = !RVALID;
  assign IRQ     = |(stat_q & mask_q);

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      aw_q <= 1'b0; w_q <= 1'b0; BVALID <= 1'b0; BRESP <= 2'h0;
      awaddr_q <= 12'h0; wdata_q <= 32'h0; wstrb_q <= 4'h0;
    end
    else
    begin
      if (AWVALID && AWREADY) begin aw_q <= 1'b1; awaddr_q <= AWADDR; end
      if (WVALID && WREADY) begin w_q <= 1'b1; wdata_q <= WDATA; wstrb_q <= WSTRB; end
      if (wr_w)
      begin
        aw_q <= 1'b0; w_q <= 1'b0; BVALID <= 1'b1;
        BRESP <= hit_w ? 2'h0 : 2'h2;
      end
      else if (BVALID && BREADY)
        BVALID <= 1'b0;
    end
  end

  // Register writes; status bits: set wins over write-one-clear
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      cfg_q <= `ACSC_CFG_RESET; div_q <= `ACSC_DIV_RESET;
      mask_q <= 2'h0; stat_q <= 2'h0; go_q <= 1'b0; long_q <= 1'b0;
    end
    else
    begin
      go_q <= 1'b0;
      if (wr_w && wstrb_q[0])
      begin
        if (awaddr_q == `ACSC_REG_CTRL && !busy_w)
        begin
          go_q <= wdata_q[0]; long_q <= wdata_q[1];
        end
        if (awaddr_q == `ACSC_REG_MASK) mask_q <= wdata_q[1:0];
      end
      if (wr_w && wstrb_q[1:0] == 2'h3)
      begin
        if (awaddr_q == `ACSC_REG_CFG) cfg_q <= wdata_q[15:0];
        if (awaddr_q == `ACSC_REG_DIV) div_q <= (wdata_q[15:0] == 16'h0) ? 16'h1 : wdata_q[15:0];
      end
      stat_q[0] <= done_w | (stat_q[0] & ~(wr_w && awaddr_q == `ACSC_REG_STAT && wdata_q[0]));
      stat_q[1] <= (done_w & ~din_s2_q) |
                   (stat_q[1] & ~(wr_w && awaddr_q == `ACSC_REG_STAT && wdata_q[1]));
    end
  end

  // Read channel
  wire [31:0] rmux_w =
    (ARADDR == `ACSC_REG_CTRL)   ? {30'h0, long_q, busy_w} :
    (ARADDR == `ACSC_REG_CFG)    ? {16'h0, cfg_q} :
    (ARADDR == `ACSC_REG_RESULT) ? {16'h0, result_q} :
    (ARADDR == `ACSC_REG_RDBK)   ? {16'h0, rdbk_q} :
    (ARADDR == `ACSC_REG_STAT)   ? {30'h0, stat_q} :
    (ARADDR == `ACSC_REG_MASK)   ? {30'h0, mask_q} :
    (ARADDR == `ACSC_REG_DIV)    ? {16'h0, div_q} : 32'h0;
  wire rhit_w = (ARADDR <= `ACSC_REG_DIV) && (ARADDR[1:0] == 2'h0);
  always_ff @(posedge CLK)
  begin
    if (SRST) begin RVALID <= 1'b0; RDATA <= 32'h0; RRESP <= 2'h0; end
    else if (ARVALID && ARREADY)
    begin
      RVALID <= 1'b1; RDATA <= rmux_w; RRESP <= rhit_w ? 2'h0 : 2'h2;
    end
    else if (RREADY) RVALID <= 1'b0;
  end

  // ==========================================================
  // Link master: clock from divider, idles low
  wire [5:0] nbits_w = long_q ? 6'd32 : 6'd16;
  wire       tick_w  = (div_cnt_q == 16'h1);
  always_ff @(posedge CLK)
  begin
    din_s1_q <= LINK.dout;
    din_s2_q <= din_s1_q;
    if (SRST)
    begin
      st_q <= ACSC_H_IDLE; div_cnt_q <= 16'h0; edge_q <= 6'h0;
      sh_out_q <= 32'h0; sh_in_q <= 32'h0; result_q <= 16'h0; rdbk_q <= 16'h0;
      LINK.sclk <= 1'b0; LINK.cs_n <= 1'b1; LINK.din <= 1'b0;
    end
    else
    begin
      div_cnt_q <= (tick_w || st_q == ACSC_H_IDLE) ? div_q : div_cnt_q - 16'h1;
      unique case (st_q)
        ACSC_H_IDLE:
          if (go_q)
          begin
            st_q <= ACSC_H_LOW; LINK.cs_n <= 1'b0; edge_q <= 6'h0;
            sh_out_q <= {cfg_q, cfg_q};
          end
        ACSC_H_LOW:
          if (tick_w)
          begin
            // Rising edge: launch next data bit
            LINK.sclk <= 1'b1; LINK.din <= sh_out_q[31];
            sh_out_q <= {sh_out_q[30:0], 1'b0}; st_q <= ACSC_H_HIGH;
          end
        ACSC_H_HIGH:
          if (tick_w)
          begin
            // Falling edge: sample device data
            LINK.sclk <= 1'b0; sh_in_q <= {sh_in_q[30:0], din_s2_q};
            edge_q <= edge_q + 6'h1;
            st_q <= (edge_q + 6'h1 == nbits_w) ? ACSC_H_END : ACSC_H_LOW;
          end
        ACSC_H_END:
        begin
          LINK.cs_n <= 1'b1; st_q <= ACSC_H_IDLE;
          result_q <= long_q ? sh_in_q[31:16] : sh_in_q[15:0];
          rdbk_q   <= long_q ? sh_in_q[15:0] : rdbk_q;
        end
      endcase
    end
  end
endmodule

// ===== verification/acsc_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Link protocol checker
module acsc_assertions #(
  parameter int TMO = 200
)(
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Link lines
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic dout_pull
);
  logic [31:0] low_q;
  logic [5:0]  rise_q;
  // Low span and rising edges in a frame, both cleared while deselected
  always_ff @(posedge CLK)
  begin
    low_q  <= (SRST || cs_n || sclk) ? 32'h0 : low_q + 32'h1;
    rise_q <= (SRST || cs_n) ? 6'h0 : rise_q + 6'($rose(sclk));
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  AST_IDLE_LOW: assert property (cs_n |-> !sclk)
    else $error("clock high while deselected");
  AST_SEL_LOW: assert property ($fell(cs_n) |-> !sclk ##1 !sclk)
    else $error("clock not low at frame start");
  AST_DIN_LAUNCH: assert property (!cs_n && !$past(cs_n) && $changed(din) |-> $rose(sclk))
    else $error("data in changed off a rising clock");
  AST_DOUT_STABLE: assert property ($fell(sclk) && !cs_n |-> $stable(dout_o))
    else $error("data out moved at falling clock");
  AST_LOW_SPAN: assert property (!cs_n |-> low_q < TMO)
    else $error("clock low too long in frame");
  AST_FRAME_LEN: assert property ($rose(cs_n) |-> rise_q == 6'h10 || rise_q == 6'h20)
    else $error("frame not 16 or 32 clocks");
  AST_SEL_DRIVE: assert property ((!cs_n)[*5] |-> dout_oe)
    else $error("line not driven while selected");
  AST_DESEL_FREE: assert property (cs_n[*5] |-> !dout_oe)
    else $error("line driven while deselected");
  AST_PULL_SEL: assert property ((!cs_n)[*5] |-> !dout_pull)
    else $error("pullup on while selected");
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
`include "acsc_params.svh"
// ==========================================
// Bench: host end and converter end face to face
module tb;
  logic        clk = 1'b0, srst = 1'b1, busy = 1'b0, rval = 1'b0, rdy, start;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0, rdat = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic [10:0] o1, o2;
  logic [15:0] cfg, w, r;
  logic [67:0] q[$], n;
  int          bad_count = 0, n_checks = 0, seed = 28, starts = 0;
  acsc_link_if lk();
  acsc_link_if lk2();
  always #2.5 clk = ~clk;
  acsc_host acsc_host_inst (.CLK(clk), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .IRQ(irq), .LINK(lk.host));
  acsc_device #(.TIMEOUT_CYC(200)) acsc_device_inst (.CLK(clk), .SRST(srst), .LINK(lk.device),
    .RESULT_DATA(rdat), .RESULT_VALID(rval), .CONV_START(start), .CONV_BUSY_CLR(),
    .CONV_BUSY(busy), .MUX_SEL(o1[10:8]), .GAIN_RANGE_SELECT(o1[7:5]), .CONTINUOUS_MODE(o1[4]),
    .SAMPLE_RATE_SELECT(o1[3:1]), .TEMPERATURE_SENSOR_SELECT(o1[0]));
  // Spare end on a second link, driven by the bench to break the timing
  acsc_device #(.TIMEOUT_CYC(200)) acsc_device_inst_2 (.CLK(clk), .SRST(srst),
    .LINK(lk2.device), .RESULT_DATA(rdat), .RESULT_VALID(rval), .CONV_START(),
    .CONV_BUSY_CLR(), .CONV_BUSY(busy), .MUX_SEL(o2[10:8]), .GAIN_RANGE_SELECT(o2[7:5]),
    .CONTINUOUS_MODE(o2[4]), .SAMPLE_RATE_SELECT(o2[3:1]), .TEMPERATURE_SENSOR_SELECT(o2[0]));
  acsc_assertions #(.TMO(200)) acsc_assertions_inst (.CLK(clk), .SRST(srst), .sclk(lk.sclk),
    .cs_n(lk.cs_n), .din(lk.din), .dout_o(lk.dout_o), .dout_oe(lk.dout_oe),
    .dout_pull(lk.dout_pull));
  function automatic logic [10:0] eo(input logic [15:0] c);
    return {c[14:12], c[11:9], ~c[8], c[7:5], c[4]};
  endfunction
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Bus cycles; each notes its expected response
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs);
    logic [2:0] h;
    @(posedge clk);
    q.push_back({2'h3, 32'h0, rs, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      h = {awvalid & awready, wvalid & wready, bvalid};
      @(posedge clk);
      if (h[2]) awvalid <= 1'b0;
      if (h[1]) wvalid <= 1'b0;
    end
    while (!h[0]);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] rs, input logic [31:0] e,
                    input logic [31:0] m);
    logic h;
    @(posedge clk);
    q.push_back({2'h3, m, rs, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      h = arready;
      @(posedge clk);
      if (h) arvalid <= 1'b0;
    end
    while (!h);
    do @(negedge clk); while (!rvalid);
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // Oldest note against each response as it is taken
  always @(negedge clk)
    if ((bvalid && bready) || (rvalid && rready))
    begin
      n = q.pop_front();
      chk((bvalid ? {bresp, 32'h0} : {rresp, rdata}) & n[67:34], n[33:0] & n[67:34]);
    end
  // Start pulses, counted mid-cycle
  always @(negedge clk)
    if (start === 1'b1) starts++;
  task automatic chkirq(input logic e);
    @(negedge clk);
    chk(34'(irq), 34'(e));
  endtask
  // One host frame of 16 or 32 clocks
  task automatic xfer(input logic [15:0] x, input logic l32);
    wr(`ACSC_REG_CFG, {16'h0, x}, 2'h0);
    wr(`ACSC_REG_CTRL, {30'h0, l32, 1'b1}, 2'h0);
    while (lk.cs_n) @(posedge clk);
    while (!lk.cs_n) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  // Bit-banged frame on the spare link; hp is the half period in cycles
  task automatic bang(input logic [15:0] x, input int hp);
    @(posedge clk);
    lk2.cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rdy = lk2.dout;
    repeat (hp - 8) @(posedge clk);
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge clk);
      lk2.sclk <= 1'b1;
      lk2.din <= x[i];
      repeat (hp - 1) @(posedge clk);
      @(negedge clk);
      r[i] = lk2.dout;
      @(posedge clk);
      lk2.sclk <= 1'b0;
      repeat (hp - 1) @(posedge clk);
    end
    @(posedge clk);
    lk2.cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    lk2.sclk = 1'b0;
    lk2.cs_n = 1'b1;
    lk2.din = 1'b0;
    cfg = `ACSC_CFG_RESET;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rdat <= 12'($random(seed));
    rval <= 1'b1;
    @(posedge clk);
    rval <= 1'b0;
    chk(34'({o1, lk.dout_pull, lk.dout_oe}), 34'({eo(cfg), 2'h2}));
    rd(`ACSC_REG_DIV, 2'h0, 32'h5, 32'hffff);
    wr(`ACSC_REG_DIV, 32'h6, 2'h0);
    wr(`ACSC_REG_MASK, 32'h1, 2'h0);
    // Idle patterns, every qualifier code, random fields, both frame lengths
    for (int i = 0; i < 8; i++)
    begin
      w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($random(seed));
      if (i > 1) w[15] = 1'b0;
      if (i > 1) w[2:1] = i[0] ? 2'(i >> 1) : 2'h1;
      xfer(w, i[0]);
      if (w[2:1] == 2'h1) cfg = {1'b0, w[14:1], 1'b1};
      chk(34'({o1, lk.dout_pull}), 34'({eo(cfg), cfg[3]}));
      if (i[0]) rd(`ACSC_REG_RDBK, 2'h0, {16'h0, cfg}, 32'hffff);
      rd(`ACSC_REG_RESULT, 2'h0, {16'h0, rdat, 4'h0}, 32'hffff);
      chkirq(1'b1);
      wr(`ACSC_REG_STAT, 32'h1, 2'h0);
      chkirq(1'b0);
    end
    // Masked event still sets status
    wr(`ACSC_REG_MASK, 32'h0, 2'h0);
    xfer(16'h0583, 1'b0);
    chkirq(1'b0);
    rd(`ACSC_REG_STAT, 2'h0, 32'h1, 32'h1);
    wr(`ACSC_REG_STAT, 32'h1, 2'h0);
    // Start refused while busy, taken once when idle, refused in continuous mode
    busy <= 1'b1;
    xfer(16'h8583, 1'b0);
    busy <= 1'b0;
    xfer(16'h8583, 1'b1);
    rd(`ACSC_REG_RDBK, 2'h0, 32'h0583, 32'hffff);
    xfer(16'h0483, 1'b0);
    xfer(16'h8583, 1'b0);
    chk(34'(starts), 34'h1);
    wr(12'h0fc, 32'h0, 2'h2);
    rd(12'h0fc, 2'h2, 32'h0, 32'h0);
    // Over-long clock low abandons the frame; a proper frame then applies
    bang(16'h0223, 250);
    chk(34'({rdy, o2}), 34'({1'b0, eo(16'h058b)}));
    bang(16'h0223, 6);
    chk(34'({r, o2, lk2.dout_pull}), 34'({rdat, 4'h0, eo(16'h0223), 1'b0}));
    results();
  end
  // Hang guard
  initial
  begin
    #400000;
    bad_count++;
    results();
  end
endmodule
